//--- design/core_exec_pkg.sv
package core_exec_pkg;

  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int REG_ADDR_W = 4;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int EVT_W = 4;

  // Instruction cycle phases
  localparam int PHASE_W = 2;
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [PHASE_W-1:0] PH_DECODE = 2'h0;
  localparam logic [PHASE_W-1:0] PH_CAPTURE = 2'h2;

  // Oscillator start-up delay, counted in oscillator periods
  localparam int CLK_PERIOD_NS = 40;
  localparam int OSC_PERIOD_NS = 40;
  localparam int OSC_STARTUP_PERIODS = 1024;
  localparam int STARTUP_CYCLES =
      (OSC_STARTUP_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CNT_W = 11;

  // Instruction fields
  localparam int FILE_LSB = 0;
  localparam int DEST_BIT = 7;
  localparam int BIT_SEL_LSB = 7;
  localparam int K8_W = 8;
  localparam int K11_W = 11;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

  // Opcodes
  localparam logic [INSTR_W-1:0] OPC_HALT = 14'h0063;
  localparam logic [INSTR_W-1:0] OPC_CLRWDT = 14'h0064;
  localparam logic [INSTR_W-1:0] OPC_RETURN = 14'h0008;
  localparam logic [INSTR_W-1:0] OPC_RETFIE = 14'h0009;
  localparam logic [2:0] GRP_CALL = 3'h4;
  localparam logic [2:0] GRP_GOTO = 3'h5;
  localparam logic [3:0] GRP_RETLW = 4'hd;
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  // Oscillator modes
  localparam logic [1:0] OSC_CRYSTAL_LOW_POWER = 2'h0;
  localparam logic [1:0] OSC_CRYSTAL_STANDARD = 2'h1;
  localparam logic [1:0] OSC_CRYSTAL_HIGH_SPEED = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL = 2'h3;

  // Register offsets
  localparam logic [REG_ADDR_W-1:0] REG_INT_CONTROL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_OSC_CONFIG = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_CONDITION = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_EVENT = 4'h3;
  localparam logic [REG_ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [REG_ADDR_W-1:0] REG_CORE = 4'h5;
  localparam logic [REG_ADDR_W-1:0] REG_ACCUM = 4'h6;
  localparam logic [REG_ADDR_W-1:0] REG_PC_LOW = 4'h7;

  // Field positions
  localparam int CTRL_GIE_BIT = 7;
  localparam int COND_TO_BIT = 4;
  localparam int COND_PD_BIT = 3;
  localparam int COND_Z_BIT = 2;
  localparam int COND_DC_BIT = 1;
  localparam int COND_C_BIT = 0;
  localparam int EVT_WAKE = 0;
  localparam int EVT_SLEEP = 1;
  localparam int EVT_HALT_NOP = 2;
  localparam int EVT_VECTOR = 3;

  // Reset values
  localparam logic [1:0] OSC_CFG_RESET = OSC_CRYSTAL_STANDARD;
  localparam logic TO_RESET = 1'b1;
  localparam logic PD_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STARTUP = 3'b100
  } core_state_type;

  function automatic logic namesFile(input logic [INSTR_W-1:0] i);
    if (i[13:12] == CLS_BIT) return 1'b1;
    if (i[13:12] != CLS_BYTE) return 1'b0;
    if (i[11:9] == 3'h0) return i[DEST_BIT];
    return 1'b1;
  endfunction

  function automatic logic isCrystal(input logic [1:0] mode);
    return mode != OSC_EXTERNAL;
  endfunction

endpackage

//--- design/phase_divider.sv
module phase_divider #(
  parameter int PHASES = core_exec_pkg::PHASES_PER_CYCLE // Oscillator periods per cycle
) (
  input wire logic clock, // Oscillator clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic run, // Advance phases while high
  output logic [core_exec_pkg::PHASE_W-1:0] phase, // Current phase
  output logic lastPhase // High in the final phase of a cycle
);
  import core_exec_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] cnt;
  } div_state_type;

  div_state_type r_reg;
  div_state_type r_next;

  if (PHASES < 4 || PHASES > (1 << PHASE_W)) begin : g_check
    $error("phase_divider: PHASES must fit the phase counter and be at least 4");
  end

  assign phase = r_reg.cnt;
  assign lastPhase = run && (r_reg.cnt == PHASE_W'(PHASES - 1));

  always_comb begin
    r_next = r_reg;
    if (run) begin
      r_next.cnt = lastPhase ? '0 : r_reg.cnt + PHASE_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule // phase_divider

//--- design/instr_alu.sv
module instr_alu (
  input wire logic [core_exec_pkg::INSTR_W-1:0] instr, // Instruction being executed
  input wire logic [core_exec_pkg::DATA_W-1:0] wIn, // Working accumulator
  input wire logic [core_exec_pkg::DATA_W-1:0] fIn, // File register value read
  input wire logic carryIn, // Current carry flag
  output logic [core_exec_pkg::DATA_W-1:0] result, // Result value
  output logic toFile, // Result goes to the file register
  output logic toW, // Result goes to the accumulator
  output logic zUpd, // Zero flag is updated
  output logic cUpd, // Carry flag is updated
  output logic dcUpd, // Digit carry flag is updated
  output logic cOut, // New carry
  output logic dcOut, // New digit carry
  output logic skip // Conditional test true: skip next
);
  import core_exec_pkg::*;

  function automatic logic [9:0] addFlags(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {lo[4], s[8], s[7:0]};
  endfunction

  logic d;
  logic [DATA_W-1:0] k;
  logic [DATA_W-1:0] mask;
  logic [9:0] addWF;
  logic [9:0] subFW;
  logic [9:0] addKW;
  logic [9:0] subKW;

  assign d = instr[DEST_BIT];
  assign k = instr[K8_W-1:0];
  assign mask = BIT_ONE << instr[BIT_SEL_LSB +: 3];
  assign addWF = addFlags(fIn, wIn, 1'b0);
  assign subFW = addFlags(fIn, ~wIn, 1'b1);
  assign addKW = addFlags(k, wIn, 1'b0);
  assign subKW = addFlags(k, ~wIn, 1'b1);

  always_comb begin
    result = 8'h00;
    toFile = 1'b0;
    toW = 1'b0;
    zUpd = 1'b0;
    cUpd = 1'b0;
    dcUpd = 1'b0;
    cOut = carryIn;
    dcOut = 1'b0;
    skip = 1'b0;
    unique case (instr[13:12])
      CLS_BYTE: begin
        toFile = d;
        toW = !d;
        unique case (instr[11:8])
          4'h0: begin
            result = wIn;
            toW = 1'b0;
          end
          4'h1: zUpd = 1'b1;
          4'h2: begin
            result = subFW[7:0];
            {dcOut, cOut} = subFW[9:8];
            {zUpd, cUpd, dcUpd} = 3'h7;
          end
          4'h3: begin
            result = fIn - 8'h01;
            zUpd = 1'b1;
          end
          4'h4: begin
            result = fIn | wIn;
            zUpd = 1'b1;
          end
          4'h5: begin
            result = fIn & wIn;
            zUpd = 1'b1;
          end
          4'h6: begin
            result = fIn ^ wIn;
            zUpd = 1'b1;
          end
          4'h7: begin
            result = addWF[7:0];
            {dcOut, cOut} = addWF[9:8];
            {zUpd, cUpd, dcUpd} = 3'h7;
          end
          4'h8: begin
            result = fIn;
            zUpd = 1'b1;
          end
          4'h9: begin
            result = ~fIn;
            zUpd = 1'b1;
          end
          4'ha: begin
            result = fIn + 8'h01;
            zUpd = 1'b1;
          end
          4'hb: begin
            result = fIn - 8'h01;
            skip = (result == 8'h00);
          end
          4'hc: begin
            result = {carryIn, fIn[7:1]};
            cOut = fIn[0];
            cUpd = 1'b1;
          end
          4'hd: begin
            result = {fIn[6:0], carryIn};
            cOut = fIn[7];
            cUpd = 1'b1;
          end
          4'he: result = {fIn[3:0], fIn[7:4]};
          4'hf: begin
            result = fIn + 8'h01;
            skip = (result == 8'h00);
          end
        endcase
      end
      CLS_BIT: begin
        unique case (instr[11:10])
          2'h0: begin
            result = fIn & ~mask;
            toFile = 1'b1;
          end
          2'h1: begin
            result = fIn | mask;
            toFile = 1'b1;
          end
          2'h2: skip = ((fIn & mask) == 8'h00);
          2'h3: skip = ((fIn & mask) != 8'h00);
        endcase
      end
      CLS_JUMP: begin
        result = 8'h00;
      end
      CLS_LIT: begin
        toW = 1'b1;
        unique casez (instr[11:8])
          4'b00??, 4'b01??: result = k;
          4'b1000: begin
            result = k | wIn;
            zUpd = 1'b1;
          end
          4'b1001: begin
            result = k & wIn;
            zUpd = 1'b1;
          end
          4'b1010: begin
            result = k ^ wIn;
            zUpd = 1'b1;
          end
          4'b110?: begin
            result = subKW[7:0];
            {dcOut, cOut} = subKW[9:8];
            {zUpd, cUpd, dcUpd} = 3'h7;
          end
          4'b111?: begin
            result = addKW[7:0];
            {dcOut, cOut} = addKW[9:8];
            {zUpd, cUpd, dcUpd} = 3'h7;
          end
          default: toW = 1'b0;
        endcase
      end
    endcase
  end

endmodule // instr_alu

//--- design/core_exec_sleep.sv
// What this block does
// - Wake source needs enable and flag set
// - Pending wake turns halt into no-operation
// - Otherwise halt completes, flags update, then wakes
// - Crystal modes wait 1024 periods after wake-up
// - Wake with global enable vectors to 0004h
// - Instructions are 14-bit opcode plus operands
// - Destination bit picks accumulator or file
// - File field addresses registers 0x00 to 0x7F
// - Bit field selects one of eight bits
// - Literals are 8 or 11 bits wide
// - One cycle equals four oscillator periods
// - Taken skip or branch costs two cycles
// - File operand is always read before written
// - Wake ignores the global interrupt enable
// - Every wake-up clears the watchdog
// - Halt opcode is 00 0000 0110 0011
module core_exec_sleep #(
  parameter int IRQ_SRC_W = 8 // Number of wake-capable interrupt sources
) (
  input wire logic clock, // Oscillator clock, 25 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [core_exec_pkg::REG_ADDR_W-1:0] regAddr, // Register address
  input wire logic [core_exec_pkg::DATA_W-1:0] regWrData, // Register write data
  input wire logic regWrite, // Register write strobe
  input wire logic regRead, // Register read strobe
  output logic [core_exec_pkg::DATA_W-1:0] regRdData, // Read data, cycle after strobe
  output logic irq, // Level interrupt, high on unmasked event
  output logic [core_exec_pkg::PC_W-1:0] progAddr, // Program memory address
  input wire logic [core_exec_pkg::INSTR_W-1:0] progData, // Program word, one cycle later
  output logic [core_exec_pkg::FADDR_W-1:0] fileAddr, // File register address
  output logic fileRdEn, // File read strobe
  input wire logic [core_exec_pkg::DATA_W-1:0] fileRdData, // File data, cycle after strobe
  output logic fileWrEn, // File write strobe
  output logic [core_exec_pkg::DATA_W-1:0] fileWrData, // File write data
  input wire logic [IRQ_SRC_W-1:0] srcEnable, // Interrupt source enable bits
  input wire logic [IRQ_SRC_W-1:0] srcFlag, // Interrupt source flag bits
  output logic watchdogClear, // Clears watchdog and prescaler
  output logic timeoutFlag, // Timeout flag
  output logic powerdownFlag, // Powerdown flag
  output logic sleeping // Core halted or starting up
);
  import core_exec_pkg::*;

  if (IRQ_SRC_W < 1) begin : g_check
    $error("core_exec_sleep: IRQ_SRC_W must be at least 1");
  end

  typedef struct packed {
    core_state_type state;
    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] ir;
    logic irValid;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] fData;
    logic z;
    logic dc;
    logic c;
    logic to;
    logic pd;
    logic global_irq_enable;
    logic [1:0] oscMode;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0] sp;
    logic [STARTUP_CNT_W-1:0] startCnt;
    logic [FADDR_W-1:0] fileAddr;
    logic fileRdEn;
    logic fileWrEn;
    logic [DATA_W-1:0] fileWrData;
    logic wdClear;
    logic irq;
    logic [DATA_W-1:0] rdData;
    logic sleeping;
  } core_reg_type;

  localparam core_reg_type CORE_RESET = '{
    state: ST_RUN,
    to: TO_RESET,
    pd: PD_RESET,
    oscMode: OSC_CFG_RESET,
    default: '0
  };

  core_reg_type r_reg;
  core_reg_type r_next;

  logic [PHASE_W-1:0] phase;
  logic lastPhase;
  logic wake;
  logic [PC_W-1:0] pcNext;
  logic jump;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClr;
  logic [DATA_W-1:0] aluResult;
  logic aluToFile;
  logic aluToW;
  logic aluZUpd;
  logic aluCUpd;
  logic aluDcUpd;
  logic aluC;
  logic aluDc;
  logic aluSkip;

  // The global enable only gates vectoring, never wake-up
  assign wake = |(srcEnable & srcFlag);

  phase_divider #(
    .PHASES(PHASES_PER_CYCLE)
  ) u_phase (
    .clock(clock),
    .resetn(resetn),
    .run(r_reg.state == ST_RUN),
    .phase(phase),
    .lastPhase(lastPhase)
  );

  instr_alu u_alu (
    .instr(r_reg.ir),
    .wIn(r_reg.w),
    .fIn(r_reg.fData),
    .carryIn(r_reg.c),
    .result(aluResult),
    .toFile(aluToFile),
    .toW(aluToW),
    .zUpd(aluZUpd),
    .cUpd(aluCUpd),
    .dcUpd(aluDcUpd),
    .cOut(aluC),
    .dcOut(aluDc),
    .skip(aluSkip)
  );

  always_comb begin
    r_next = r_reg;
    pcNext = r_reg.pc;
    jump = 1'b0;
    evtSet = '0;
    evtClr = '0;
    r_next.fileRdEn = 1'b0;
    r_next.fileWrEn = 1'b0;
    r_next.wdClear = 1'b0;
    r_next.rdData = 8'h00;

    if (regWrite) begin
      unique case (regAddr)
        REG_INT_CONTROL: r_next.global_irq_enable = regWrData[CTRL_GIE_BIT];
        REG_OSC_CONFIG: r_next.oscMode = regWrData[1:0];
        REG_CONDITION: begin
          r_next.z = regWrData[COND_Z_BIT];
          r_next.dc = regWrData[COND_DC_BIT];
          r_next.c = regWrData[COND_C_BIT];
        end
        REG_EVENT: evtClr = regWrData[EVT_W-1:0];
        REG_MASK: r_next.mask = regWrData[EVT_W-1:0];
        default: ;
      endcase
    end

    if (regRead) begin
      unique case (regAddr)
        REG_INT_CONTROL: r_next.rdData = {r_reg.global_irq_enable, 7'h00};
        REG_OSC_CONFIG: r_next.rdData = {6'h00, r_reg.oscMode};
        // Software tells a skipped halt by a powerdown flag still set
        REG_CONDITION: r_next.rdData = {3'h0, r_reg.to, r_reg.pd, r_reg.z, r_reg.dc, r_reg.c};
        REG_EVENT: r_next.rdData = {4'h0, r_reg.evt};
        REG_MASK: r_next.rdData = {4'h0, r_reg.mask};
        REG_CORE: r_next.rdData = {4'h0, wake, r_reg.state};
        REG_ACCUM: r_next.rdData = r_reg.w;
        REG_PC_LOW: r_next.rdData = r_reg.pc[7:0];
        default: r_next.rdData = 8'h00;
      endcase
    end

    unique case (r_reg.state)
      ST_RUN: begin
        // Every file operand is read, even by write-only instructions
        if (phase == PH_DECODE && r_reg.irValid && namesFile(r_reg.ir)) begin
          r_next.fileAddr = r_reg.ir[FILE_LSB +: FADDR_W];
          r_next.fileRdEn = 1'b1;
        end
        if (phase == PH_CAPTURE) begin
          r_next.fData = fileRdData;
        end
        if (lastPhase) begin
          pcNext = r_reg.pc + PC_W'(1);
          r_next.ir = progData;
          r_next.irValid = 1'b1;
          if (r_reg.irValid) begin
            if (r_reg.ir == OPC_HALT) begin
              if (wake) begin
                evtSet[EVT_HALT_NOP] = 1'b1;
              end else begin
                r_next.pd = 1'b0;
                r_next.to = 1'b1;
                r_next.wdClear = 1'b1;
                r_next.state = ST_SLEEP;
                evtSet[EVT_SLEEP] = 1'b1;
              end
            end
            if (r_reg.ir == OPC_CLRWDT) begin
              r_next.wdClear = 1'b1;
              r_next.to = 1'b1;
              r_next.pd = 1'b1;
            end
            if (r_reg.ir[13:11] == GRP_GOTO || r_reg.ir[13:11] == GRP_CALL) begin
              jump = 1'b1;
              pcNext = {r_reg.pc[PC_W-1:K11_W], r_reg.ir[K11_W-1:0]};
            end
            if (r_reg.ir[13:11] == GRP_CALL) begin
              r_next.stack[r_reg.sp] = r_reg.pc;
              r_next.sp = r_reg.sp + SP_W'(1);
            end
            if (r_reg.ir == OPC_RETURN || r_reg.ir == OPC_RETFIE ||
                r_reg.ir[13:10] == GRP_RETLW) begin
              jump = 1'b1;
              pcNext = r_reg.stack[r_reg.sp - SP_W'(1)];
              r_next.sp = r_reg.sp - SP_W'(1);
            end
            if (r_reg.ir == OPC_RETFIE) begin
              r_next.global_irq_enable = 1'b1;
            end
            if (aluSkip) begin
              jump = 1'b1;
            end
            if (aluToW) begin
              r_next.w = aluResult;
            end
            if (aluToFile) begin
              r_next.fileWrEn = 1'b1;
              r_next.fileWrData = aluResult;
              r_next.fileAddr = r_reg.ir[FILE_LSB +: FADDR_W];
            end
            if (aluZUpd) begin
              r_next.z = (aluResult == 8'h00);
            end
            if (aluCUpd) begin
              r_next.c = aluC;
            end
            if (aluDcUpd) begin
              r_next.dc = aluDc;
            end
            // Vector only after a straight-line instruction so the stack takes one push
            if (r_reg.global_irq_enable && wake && !jump && r_next.state == ST_RUN) begin
              r_next.stack[r_reg.sp] = pcNext;
              r_next.sp = r_reg.sp + SP_W'(1);
              pcNext = IRQ_VECTOR;
              r_next.global_irq_enable = 1'b0;
              jump = 1'b1;
              evtSet[EVT_VECTOR] = 1'b1;
            end
          end
          r_next.pc = pcNext;
          if (jump) begin
            r_next.irValid = 1'b0;
          end
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          r_next.wdClear = 1'b1;
          evtSet[EVT_WAKE] = 1'b1;
          if (isCrystal(r_reg.oscMode)) begin
            r_next.state = ST_STARTUP;
            r_next.startCnt = STARTUP_CNT_W'(STARTUP_CYCLES - 1);
          end else begin
            r_next.state = ST_RUN;
          end
        end
      end
      ST_STARTUP: begin
        if (r_reg.startCnt == '0) begin
          r_next.state = ST_RUN;
        end else begin
          r_next.startCnt = r_reg.startCnt - STARTUP_CNT_W'(1);
        end
      end
    endcase

    // A new event wins over a clear in the same cycle
    r_next.evt = (r_reg.evt & ~evtClr) | evtSet;
    r_next.irq = |(r_next.evt & r_next.mask);
    r_next.sleeping = (r_next.state != ST_RUN);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r_reg <= CORE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign regRdData = r_reg.rdData;
  assign irq = r_reg.irq;
  assign progAddr = r_reg.pc;
  assign fileAddr = r_reg.fileAddr;
  assign fileRdEn = r_reg.fileRdEn;
  assign fileWrEn = r_reg.fileWrEn;
  assign fileWrData = r_reg.fileWrData;
  assign watchdogClear = r_reg.wdClear;
  assign timeoutFlag = r_reg.to;
  assign powerdownFlag = r_reg.pd;
  assign sleeping = r_reg.sleeping;

endmodule // core_exec_sleep

//--- dv/core_exec_sleep_monitor.sv
module core_exec_sleep_monitor #(
  parameter int IRQ_SRC_W = 8 // Wake sources
) (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset
  input wire logic [core_exec_pkg::PC_W-1:0] progAddr, // Fetch address
  input wire logic fileRdEn, // File read
  input wire logic fileWrEn, // File write
  input wire logic [IRQ_SRC_W-1:0] srcEnable, // Enables
  input wire logic [IRQ_SRC_W-1:0] srcFlag, // Flags
  input wire logic watchdogClear, // Watchdog clear
  input wire logic timeoutFlag, // Timeout flag
  input wire logic powerdownFlag, // Powerdown flag
  input wire logic sleeping // Halted
);
  logic wake, prevSleep, dozing, asleep;
  assign wake = |(srcEnable & srcFlag);
  // Halted and not yet woken, so startup time is excluded
  assign asleep = sleeping && (dozing || !prevSleep);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prevSleep <= 1'b0;
      dozing <= 1'b0;
    end else begin
      prevSleep <= sleeping;
      dozing <= asleep && !wake;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_entry; $rose(sleeping) |-> !powerdownFlag && timeoutFlag && watchdogClear; endproperty
  property p_pd; $fell(powerdownFlag) |-> $rose(sleeping); endproperty
  property p_wake; asleep && wake |=> watchdogClear; endproperty
  property p_stay; asleep && !wake |=> sleeping; endproperty
  property p_resume; $fell(sleeping) |-> !powerdownFlag && timeoutFlag; endproperty
  property p_hold; $changed(progAddr) && !sleeping |=> $stable(progAddr)[*3]; endproperty
  property p_once; fileRdEn |=> !fileRdEn[*3]; endproperty
  property p_rmw; fileWrEn |-> $past(fileRdEn, 3) || $past(fileRdEn, 4); endproperty
  a_entry: assert property (p_entry) else $error("sleep entry flags wrong");
  a_pd: assert property (p_pd) else $error("powerdown cleared without halt");
  a_wake: assert property (p_wake) else $error("wake without watchdog clear");
  a_stay: assert property (p_stay) else $error("left halt without wake");
  a_resume: assert property (p_resume) else $error("flags wrong on resume");
  a_hold: assert property (p_hold) else $error("cycle not four clocks");
  a_once: assert property (p_once) else $error("two reads in a cycle");
  a_rmw: assert property (p_rmw) else $error("write without prior read");
  c_sleep: cover property ($rose(sleeping));
  c_wake: cover property (asleep && wake);
  c_rmw: cover property (fileWrEn);
endmodule // core_exec_sleep_monitor

//--- dv/prog_mem_model.sv
module prog_mem_model (
  input wire logic clock, // Clock
  input wire logic [core_exec_pkg::PC_W-1:0] progAddr, // Fetch address
  output logic [core_exec_pkg::INSTR_W-1:0] progData, // Word
  input wire logic [core_exec_pkg::FADDR_W-1:0] fileAddr, // File address
  input wire logic fileRdEn, // File read
  output logic [core_exec_pkg::DATA_W-1:0] fileRdData, // File data
  input wire logic fileWrEn, // File write
  input wire logic [core_exec_pkg::DATA_W-1:0] fileWrData // Write data
);
  import core_exec_pkg::*;
  logic [INSTR_W-1:0] rom [64];
  logic [DATA_W-1:0] ram [128];
  initial fileRdData = 8'h00;
  // Idle read data toggles so a late sample cannot match by luck
  always @(posedge clock) begin
    progData <= rom[progAddr[5:0]];
    fileRdData <= fileRdEn ? ram[fileAddr] : ~fileRdData;
    if (fileWrEn) begin
      ram[fileAddr] <= fileWrData;
    end
  end
endmodule // prog_mem_model

//--- dv/core_exec_sleep_bench.sv
module core_exec_sleep_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import core_exec_pkg::*;
  logic clock, resetn, regWrite, regRead, irq, fileRdEn, fileWrEn;
  logic watchdogClear, timeoutFlag, powerdownFlag, sleeping, hit;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, fileRdData, fileWrData;
  logic [PC_W-1:0] progAddr;
  logic [INSTR_W-1:0] progData;
  logic [FADDR_W-1:0] fileAddr;
  logic [7:0] srcEnable, srcFlag;
  int failures = 0, checks = 0, cyc = 0, n, rdCnt, wrCnt;
  core_exec_sleep i_dut (.clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .irq(irq), .progAddr(progAddr), .progData(progData), .fileAddr(fileAddr),
    .fileRdEn(fileRdEn), .fileRdData(fileRdData), .fileWrEn(fileWrEn),
    .fileWrData(fileWrData), .srcEnable(srcEnable), .srcFlag(srcFlag),
    .watchdogClear(watchdogClear), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag), .sleeping(sleeping));
  prog_mem_model i_mem (.clock(clock), .progAddr(progAddr), .progData(progData),
    .fileAddr(fileAddr), .fileRdEn(fileRdEn), .fileRdData(fileRdData),
    .fileWrEn(fileWrEn), .fileWrData(fileWrData));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    rdCnt = !resetn ? 0 : rdCnt + int'(fileRdEn);
    wrCnt = !resetn ? 0 : wrCnt + int'(fileWrEn);
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  task complete_run;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task rst;
    resetn <= 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task rdr(input logic [3:0] a, input logic [7:0] e, input string m);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData, e, m);
    @(posedge clock);
  endtask
  task irq_is(input logic e);
    @(negedge clock);
    chk({7'h0, irq}, {7'h0, e}, "irq level");
    @(posedge clock);
  endtask
  task wait_sleep;
    n = 0;
    while (sleeping !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk({7'h0, sleeping}, 8'h01, "halt never reached");
    @(posedge clock);
  endtask
  task s_nop;
    srcEnable <= 8'h01;
    srcFlag <= 8'h01;
    rst;
    n = 0;
    repeat (80) begin
      @(negedge clock);
      n += int'(sleeping !== 1'b0);
    end
    @(posedge clock);
    chk(n[7:0], 8'h00, "halt slept with wake pending");
    rdr(REG_CONDITION, 8'h18, "flags moved by skipped halt");
    rdr(REG_EVENT, 8'h04, "skipped halt event");
  endtask
  task s_sleep(input logic [1:0] mode, input logic global_irq_enable);
    srcEnable <= 8'h01;
    srcFlag <= 8'h02;
    rst;
    wr(REG_OSC_CONFIG, {6'h0, mode});
    wr(REG_INT_CONTROL, {global_irq_enable, 7'h0});
    wr(REG_MASK, 8'h02);
    wait_sleep;
    rdr(REG_CONDITION, 8'h10, "halt flags");
    irq_is(1'b1);
    wr(REG_MASK, 8'h00);
    irq_is(1'b0);
    wr(REG_MASK, 8'h02);
    wr(REG_EVENT, 8'h02);
    irq_is(1'b0);
    srcFlag <= 8'h03;
    n = 0;
    while (sleeping === 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    chk({7'h0, (mode != OSC_EXTERNAL) ? (n >= 1024 && n <= 1030) : (n <= 3)}, 8'h01,
        "startup delay");
    hit = 1'b0;
    repeat (40) begin
      @(negedge clock);
      hit |= (progAddr === IRQ_VECTOR);
    end
    chk({7'h0, hit}, {7'h0, global_irq_enable}, "vector after wake");
    @(posedge clock);
    srcFlag <= 8'h00;
    // Vectoring runs on into the halt while wake is still pending, so that halt is skipped
    rdr(REG_EVENT, {4'h0, global_irq_enable, global_irq_enable, 2'h1}, "wake events");
  endtask
  task s_rmw;
    i_mem.rom[0] = 14'h2803;
    i_mem.rom[1] = 14'h0aff;
    i_mem.rom[3] = 14'h17ff;
    i_mem.rom[4] = 14'h0aff;
    i_mem.rom[5] = 14'h0a7f;
    i_mem.rom[6] = OPC_HALT;
    i_mem.ram[127] = 8'h41;
    srcEnable <= 8'h00;
    rst;
    wait_sleep;
    chk(i_mem.ram[127], 8'hc2, "file result");
    rdr(REG_ACCUM, 8'hc3, "accumulator result");
    chk(rdCnt[7:0], 8'h03, "file reads");
    chk(wrCnt[7:0], 8'h02, "file writes");
  endtask
  initial begin
    resetn = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    srcEnable = '0;
    srcFlag = '0;
    for (int i = 0; i < 64; i++) begin
      i_mem.rom[i] = 14'h0000;
    end
    i_mem.rom[8] = OPC_HALT;
    rst;
    rdr(REG_CONDITION, 8'h18, "condition reset");
    rdr(4'h8, 8'h00, "unmapped read");
    s_nop;
    s_sleep(OSC_CRYSTAL_STANDARD, 1'b0);
    s_sleep(OSC_CRYSTAL_LOW_POWER, 1'b1);
    s_sleep(OSC_CRYSTAL_HIGH_SPEED, 1'b0);
    s_sleep(OSC_EXTERNAL, 1'b1);
    s_rmw;
    complete_run;
  end
endmodule // core_exec_sleep_bench
bind core_exec_sleep core_exec_sleep_monitor #(.IRQ_SRC_W(IRQ_SRC_W)) i_mon (.clock(clock),
  .resetn(resetn), .progAddr(progAddr), .fileRdEn(fileRdEn), .fileWrEn(fileWrEn),
  .srcEnable(srcEnable), .srcFlag(srcFlag), .watchdogClear(watchdogClear),
  .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .sleeping(sleeping));
